// *** gpc_map.svh ***
`ifndef GPC_MAP_SVH
`define GPC_MAP_SVH

// Register offsets
`define GPC_OFS_GPIO      8'h0E
`define GPC_OFS_I2C       8'h0F

// Reset values
`define GPC_RST_GPIO      8'h35
`define GPC_RST_I2C       8'h00

// Pin field positions, relative to the pin's nibble
`define GPC_PIN_EN        0
`define GPC_PIN_DIR       1
`define GPC_PIN_REM       2
`define GPC_PIN_VAL       3
`define GPC_PIN_STRIDE    4

// I2C master config fields
`define GPC_I2C_WD_DIS    0
`define GPC_I2C_WD_FAST   1
`define GPC_I2C_WP        2
`define GPC_I2C_DLY_LO    3
`define GPC_I2C_DLY_HI    4
`define GPC_I2C_USED      5

// Timing
`define GPC_CLK_NS        20
`define GPC_SDA_BASE_NS   350
`define GPC_SDA_STEP_NS   50
`define GPC_WD_FAST_US    50
`define GPC_WD_SLOW_MS    1000
`define GPC_RCV_HALF_NS   5000
`define GPC_RCV_PULSES    9

// Counter widths
`define GPC_WD_W          32
`define GPC_DLY_W         5
`define GPC_DIV_W         9

`endif

// *** gpc_pkg.sv ***
package gpc_pkg;
`include "gpc_map.svh"

   // Watchdog and bus-recovery sequencer
   typedef enum logic [2:0] {
      GPC_WATCH    = 3'b001,
      GPC_RCV_LOW  = 3'b010,
      GPC_RCV_HIGH = 3'b100
   } gpc_wd_e;

   // Whole block state
   typedef struct packed {
      logic [7:0]              regGpio;
      logic [7:0]              regI2c;
      logic [7:0]              rdData;
      logic                    wrRejected;
      logic [1:0]              pinOut;
      logic [1:0]              pinOe;
      logic [`GPC_WD_W-1:0]    wdCnt;
      logic                    sclPrev;
      logic                    sdaPrev;
      logic                    busFree;
      gpc_wd_e                 wdState;
      logic [3:0]              rcvPulses;
      logic [`GPC_DIV_W-1:0]   rcvDiv;
      logic                    sclOe;
      logic                    sdaTarget;
      logic                    sdaOe;
      logic [`GPC_DLY_W-1:0]   sdaDlyCnt;
   } gpc_state_s;

endpackage

// *** gpc_cfg.sv ***
`timescale 1ns/100ps
`include "gpc_map.svh"

module gpc_cfg
   import gpc_pkg::*;
#(
   parameter int unsigned WD_SLOW_CYC =
      `GPC_WD_SLOW_MS * 1000 * (1000 / `GPC_CLK_NS)
)(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // Local register port
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWr,
   input  wire logic       regFromRemote,
   output logic      [7:0] regRdData,
   output logic            regWrRejected,
   // Forwarded access to slaves behind this side
   input  wire logic       fwdReq,
   output logic            fwdGo,
   // Values received from the remote end
   input  wire logic [1:0] remotePinVal,
   // Third and fourth general pins
   input  wire logic       thirdGeneralPinIn,
   output logic            thirdGeneralPinOut,
   output logic            thirdGeneralPinOe,
   input  wire logic       fourthGeneralPinIn,
   output logic            fourthGeneralPinOut,
   output logic            fourthGeneralPinOe,
   // Local I2C master core requests
   input  wire logic       sclReqLow,
   input  wire logic       sdaReqLow,
   // Open-drain I2C pins
   input  wire logic       sclIn,
   output logic            sclOut,
   output logic            sclOe,
   input  wire logic       sdaIn,
   output logic            sdaOut,
   output logic            sdaOe,
   // Watchdog status
   output logic            busFree,
   output logic            busRecovering
);

   localparam int unsigned WD_FAST_CYC =
      `GPC_WD_FAST_US * 1000 / `GPC_CLK_NS;
   localparam int unsigned RCV_HALF_CYC =
      `GPC_RCV_HALF_NS / `GPC_CLK_NS;

   // Refuse counts the counters cannot hold
   if (WD_SLOW_CYC <= WD_FAST_CYC ||
       WD_SLOW_CYC > 32'hFFFF_FFFF)
      $error("gpc_cfg: WD_SLOW_CYC out of range");
   if (RCV_HALF_CYC >= (1 << `GPC_DIV_W))
      $error("gpc_cfg: recovery divider too narrow");

   // SDA delay in cycles, rounded up as a least time
   function automatic logic [`GPC_DLY_W-1:0] sdaDelayCyc(
      input logic [1:0] code
   );
      int unsigned ns;
      ns = `GPC_SDA_BASE_NS + `GPC_SDA_STEP_NS * code;
      return `GPC_DLY_W'((ns + `GPC_CLK_NS - 1) / `GPC_CLK_NS);
   endfunction

   // Field pick-out for one pin's nibble
   function automatic logic pinBit(
      input logic [7:0] r,
      input int         pin,
      input int         pos
   );
      return r[pin * `GPC_PIN_STRIDE + pos];
   endfunction

   gpc_state_s st;
   gpc_state_s next_st;
   logic       wrAllowed;
   logic       busEdge;
   logic       wdExpire;
   logic [`GPC_WD_W-1:0] wdLimit;
   logic [1:0] dlyCode;

   // Next-state logic
   always_comb begin
      next_st = st;
      dlyCode = st.regI2c[`GPC_I2C_DLY_HI:`GPC_I2C_DLY_LO];

      // Remote writes refused under write-protect
      wrAllowed = regWr &&
         !(regFromRemote && st.regI2c[`GPC_I2C_WP]);
      next_st.wrRejected = regWr && !wrAllowed;
      if (wrAllowed) begin
         if (regAddr == `GPC_OFS_GPIO) begin
            next_st.regGpio = regWrData;
         end else if (regAddr == `GPC_OFS_I2C) begin
            next_st.regI2c = {3'h0,
               regWrData[`GPC_I2C_USED-1:0]};
         end
      end

      // Read data is registered; unmapped offsets read zero
      if (regAddr == `GPC_OFS_GPIO) begin
         next_st.rdData = st.regGpio;
      end else if (regAddr == `GPC_OFS_I2C) begin
         next_st.rdData = st.regI2c;
      end else begin
         next_st.rdData = 8'h00;
      end

      // Pin drive; remote control outranks local settings
      for (int p = 0; p < 2; p++) begin
         if (pinBit(st.regGpio, p, `GPC_PIN_REM)) begin
            next_st.pinOe[p]  = 1'b1;
            next_st.pinOut[p] = remotePinVal[p];
         end else begin
            next_st.pinOe[p] =
               pinBit(st.regGpio, p, `GPC_PIN_EN) &&
               !pinBit(st.regGpio, p, `GPC_PIN_DIR);
            next_st.pinOut[p] =
               pinBit(st.regGpio, p, `GPC_PIN_VAL);
         end
      end

      // SDA output delay: restart on every new request level
      if (sdaReqLow != st.sdaTarget) begin
         next_st.sdaTarget = sdaReqLow;
         next_st.sdaDlyCnt = sdaDelayCyc(dlyCode) -
            `GPC_DLY_W'(1);
      end else if (st.sdaDlyCnt != '0) begin
         next_st.sdaDlyCnt = st.sdaDlyCnt - `GPC_DLY_W'(1);
         if (st.sdaDlyCnt == `GPC_DLY_W'(1)) begin
            next_st.sdaOe = st.sdaTarget;
         end
      end

      // Bus activity seen on either line
      next_st.sclPrev = sclIn;
      next_st.sdaPrev = sdaIn;
      busEdge = (sclIn != st.sclPrev) || (sdaIn != st.sdaPrev);

      wdLimit = st.regI2c[`GPC_I2C_WD_FAST] ?
         `GPC_WD_W'(WD_FAST_CYC) :
         `GPC_WD_W'(WD_SLOW_CYC);
      wdExpire = 1'b0;
      next_st.sclOe = sclReqLow;

      case (st.wdState)
         GPC_WATCH: begin
            if (st.regI2c[`GPC_I2C_WD_DIS]) begin
               next_st.wdCnt = '0;
            end else if (busEdge) begin
               next_st.wdCnt   = '0;
               next_st.busFree = 1'b0;
            end else if (st.wdCnt >= wdLimit - 1) begin
               wdExpire      = 1'b1;
               next_st.wdCnt = '0;
               if (sdaIn) begin
                  next_st.busFree = 1'b1;
               end else begin
                  next_st.wdState   = GPC_RCV_LOW;
                  next_st.rcvPulses = 4'h0;
                  next_st.rcvDiv    = '0;
               end
            end else begin
               next_st.wdCnt = st.wdCnt + 1'b1;
            end
         end
         GPC_RCV_LOW: begin
            // Own clocking overrides the master core
            next_st.sclOe  = 1'b1;
            next_st.rcvDiv = st.rcvDiv + 1'b1;
            if (st.rcvDiv == `GPC_DIV_W'(RCV_HALF_CYC - 1)) begin
               next_st.rcvDiv  = '0;
               next_st.sclOe   = 1'b0;
               next_st.wdState = GPC_RCV_HIGH;
            end
         end
         GPC_RCV_HIGH: begin
            // A slave stretching SCL would shorten this phase;
            // recovery is best effort and ignores stretching
            next_st.sclOe  = 1'b0;
            next_st.rcvDiv = st.rcvDiv + 1'b1;
            if (st.rcvDiv == `GPC_DIV_W'(RCV_HALF_CYC - 1)) begin
               next_st.rcvDiv    = '0;
               next_st.rcvPulses = st.rcvPulses + 4'h1;
               if (st.rcvPulses == 4'(`GPC_RCV_PULSES - 1)) begin
                  next_st.wdState = GPC_WATCH;
                  next_st.wdCnt   = '0;
               end else begin
                  next_st.sclOe   = 1'b1;
                  next_st.wdState = GPC_RCV_LOW;
               end
            end
         end
         default: begin
            next_st.wdState = GPC_WATCH;
            next_st.wdCnt   = '0;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st           <= '0;
         st.regGpio   <= `GPC_RST_GPIO;
         st.regI2c    <= `GPC_RST_I2C;
         st.sclPrev   <= 1'b1;
         st.sdaPrev   <= 1'b1;
         st.sdaTarget <= 1'b0;
         st.wdState   <= GPC_WATCH;
      end else begin
         st <= next_st;
      end
   end

   // Forwarded slave traffic bypasses the write-protect gate
   assign fwdGo = fwdReq;

   // Outputs
   assign regRdData           = st.rdData;
   assign regWrRejected       = st.wrRejected;
   assign thirdGeneralPinOut  = st.pinOut[0];
   assign thirdGeneralPinOe   = st.pinOe[0];
   assign fourthGeneralPinOut = st.pinOut[1];
   assign fourthGeneralPinOe  = st.pinOe[1];
   assign sclOut              = 1'b0;  // Open drain: only pulls low
   assign sclOe               = st.sclOe;
   assign sdaOut              = 1'b0;
   assign sdaOe               = st.sdaOe;
   assign busFree             = st.busFree;
   assign busRecovering       = (st.wdState != GPC_WATCH);

   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   property p_pin_local;
      !st.regGpio[`GPC_PIN_REM] |=>
         thirdGeneralPinOe == $past(st.regGpio[`GPC_PIN_EN] &&
            !st.regGpio[`GPC_PIN_DIR]) &&
         thirdGeneralPinOut == $past(st.regGpio[`GPC_PIN_VAL]);
   endproperty
   a_pin_local: assert property (p_pin_local)
      else $error("third pin local drive wrong");

   property p_pin_remote;
      st.regGpio[`GPC_PIN_STRIDE + `GPC_PIN_REM] |=>
         fourthGeneralPinOe &&
         fourthGeneralPinOut == $past(remotePinVal[1]);
   endproperty
   a_pin_remote: assert property (p_pin_remote)
      else $error("fourth pin remote drive wrong");

   property p_sda_load;
      (sdaReqLow != st.sdaTarget) |=>
         st.sdaDlyCnt == sdaDelayCyc($past(dlyCode)) - 5'h01;
   endproperty
   a_sda_load: assert property (p_sda_load)
      else $error("SDA delay count loaded wrong");

   property p_sda_apply;
      (st.sdaDlyCnt == 5'h01 && sdaReqLow == st.sdaTarget) |=>
         sdaOe == $past(st.sdaTarget);
   endproperty
   a_sda_apply: assert property (p_sda_apply)
      else $error("SDA not applied after delay");

   property p_wp_reject;
      (regWr && regFromRemote && st.regI2c[`GPC_I2C_WP]) |=>
         regWrRejected && $stable(st.regGpio) && $stable(st.regI2c);
   endproperty
   a_wp_reject: assert property (p_wp_reject)
      else $error("protected remote write took effect");

   property p_fwd_pass;
      (fwdReq && st.regI2c[`GPC_I2C_WP]) |-> fwdGo;
   endproperty
   a_fwd_pass: assert property (p_fwd_pass)
      else $error("forwarded access blocked");

   property p_wd_fast;
      (st.regI2c[`GPC_I2C_WD_FAST] && $past(st.regI2c[`GPC_I2C_WD_FAST])
         && st.wdState == GPC_WATCH) |-> st.wdCnt < 32'(WD_FAST_CYC);
   endproperty
   a_wd_fast: assert property (p_wd_fast)
      else $error("fast watchdog overran");

   property p_wd_slow;
      wdExpire && !st.regI2c[`GPC_I2C_WD_FAST] |->
         st.wdCnt == 32'(WD_SLOW_CYC - 1);
   endproperty
   a_wd_slow: assert property (p_wd_slow)
      else $error("slow watchdog expired early");

   property p_wd_off;
      st.regI2c[`GPC_I2C_WD_DIS] && st.wdState == GPC_WATCH
         |=> st.wdCnt == '0 && st.wdState == GPC_WATCH;
   endproperty
   a_wd_off: assert property (p_wd_off)
      else $error("disabled watchdog still counting");

   property p_free;
      (wdExpire && sdaIn) |=> busFree;
   endproperty
   a_free: assert property (p_free)
      else $error("bus not marked free");

   property p_recover;
      (wdExpire && !sdaIn) |=> busRecovering ##1 sclOe;
   endproperty
   a_recover: assert property (p_recover)
      else $error("bus recovery not started");

   property p_restart;
      (st.wdState == GPC_WATCH && busEdge) |=> st.wdCnt == '0;
   endproperty
   a_restart: assert property (p_restart)
      else $error("watchdog not restarted by edge");

endmodule

// *** gpc_far_model.sv ***
`timescale 1ns/100ps

// Far side: remote pin values and the pulled-up I2C lines
module gpc_far_model (
   // Clock
   input  wire logic       clk_sys,
   // Bench commands
   input  wire logic       holdSdaLow,
   input  wire logic [1:0] pinCmd,
   // Open-drain enables of the block
   input  wire logic       sclOe,
   input  wire logic       sdaOe,
   // Toward the block
   output logic            sclIn,
   output logic            sdaIn,
   output logic [1:0]      remotePinVal
);
   // Pull-ups win unless some party pulls low; a stuck slave holds SDA
   assign sclIn = !sclOe;
   assign sdaIn = !(sdaOe || holdSdaLow);

   // Remote pin values land one cycle late, like a hop over the link
   always_ff @(posedge clk_sys) begin
      remotePinVal <= pinCmd;
   end
endmodule

// *** gpc_cfg_test.sv ***
`timescale 1ns/100ps

module gpc_cfg_test;
   import gpc_pkg::*;
   logic       clk_sys, rst, regWr, regFromRemote, fwdReq, fwdGo;
   logic       regWrRejected, sclReqLow, sdaReqLow, sclIn, sclOe, sdaIn;
   logic       sdaOe, busFree, busRecovering, holdSdaLow, lastRej, prev;
   logic       p3Out, p3Oe, p4Out, p4Oe, sclDrv, sdaDrv;
   logic [7:0] regAddr, regWrData, regRdData;
   logic [1:0] pinCmd, remotePinVal;
   int         errTotal, samplesChecked, n, m;

   // Short watchdog count keeps the slow mode inside the run
   gpc_cfg #(.WD_SLOW_CYC(3000)) uut (
      .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regFromRemote(regFromRemote),
      .regRdData(regRdData), .regWrRejected(regWrRejected),
      .fwdReq(fwdReq), .fwdGo(fwdGo), .remotePinVal(remotePinVal),
      .thirdGeneralPinIn(p3Oe ? p3Out : 1'b1),
      .thirdGeneralPinOut(p3Out), .thirdGeneralPinOe(p3Oe),
      .fourthGeneralPinIn(p4Oe ? p4Out : 1'b1),
      .fourthGeneralPinOut(p4Out), .fourthGeneralPinOe(p4Oe),
      .sclReqLow(sclReqLow), .sdaReqLow(sdaReqLow), .sclIn(sclIn),
      .sclOut(sclDrv), .sclOe(sclOe), .sdaIn(sdaIn), .sdaOut(sdaDrv),
      .sdaOe(sdaOe), .busFree(busFree), .busRecovering(busRecovering)
   );

   gpc_far_model far (
      .clk_sys(clk_sys), .holdSdaLow(holdSdaLow), .pinCmd(pinCmd),
      .sclOe(sclOe), .sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn),
      .remotePinVal(remotePinVal)
   );

   // 50 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // Wide enough for cycle counts as well as register bytes
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         errTotal++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One-cycle write strobe; refusal pulse captured after the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic rem);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      regFromRemote <= rem;
      @(posedge clk_sys);
      regWr <= 1'b0;
      @(negedge clk_sys);
      lastRej = regWrRejected;
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      regAddr <= a;
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk(regRdData, exp);
   endtask

   // Wait k edges, then sample where outputs have settled
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask

   // Short SCL pull gives the watchdog a bus edge
   task automatic kick;
      @(posedge clk_sys);
      sclReqLow <= 1'b1;
      @(posedge clk_sys);
      sclReqLow <= 1'b0;
   endtask

   // Edges from the request change to the SDA enable change
   task automatic sdaMeasure(input logic lvl, input int exp);
      @(posedge clk_sys);
      sdaReqLow <= lvl;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
         @(negedge clk_sys);
      end while (sdaOe !== lvl && n < 100);
      chk(n, exp);
   endtask

   // Expected {oe, out} of one pin from its nibble and remote value
   function automatic logic [1:0] pinExp(input logic [3:0] c,
                                         input logic r);
      if (c[2]) return {1'b1, r};
      return {c[0] & !c[1], c[3]};
   endfunction

   task automatic reportAndStop;
      if (errTotal == 0 && samplesChecked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      rst = 1'b1;
      {regWr, regFromRemote, fwdReq, sclReqLow, sdaReqLow} = '0;
      {regAddr, regWrData, pinCmd, holdSdaLow} = '0;
      errTotal = 0;
      samplesChecked = 0;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      rdChk(8'h0E, 8'h35);
      rdChk(8'h0F, 8'h00);
      rdChk(8'h40, 8'h00);
      // Every nibble code, odd codes written over the channel, while unprotected
      for (int v = 0; v < 16; v++) begin
         @(posedge clk_sys);
         pinCmd <= v[1:0];
         wr(8'h0E, {v[3:0], v[3:0]}, v[0]);
         chk(lastRej, 1'b0);
         rdChk(8'h0E, {v[3:0], v[3:0]});
         chk({p4Oe, p4Out, p3Oe, p3Out},
             {pinExp(v[3:0], v[1]), pinExp(v[3:0], v[0])});
      end
      // Protection: remote write refused, local write and forwarding pass
      wr(8'h0F, 8'hE4, 1'b0);
      rdChk(8'h0F, 8'h04);
      wr(8'h0E, 8'h00, 1'b1);
      chk(lastRej, 1'b1);
      rdChk(8'h0E, 8'hFF);
      @(posedge clk_sys);
      fwdReq <= 1'b1;
      @(negedge clk_sys);
      chk(fwdGo, 1'b1);
      wr(8'h0E, 8'h11, 1'b0);
      chk(lastRej, 1'b0);
      rdChk(8'h0E, 8'h11);
      // SDA delay codes, both directions, rounded up to whole cycles
      for (int c = 0; c < 4; c++) begin
         wr(8'h0F, {3'h0, c[1:0], 3'h0}, 1'b0);
         sdaMeasure(1'b1, (350 + 50 * c + 19) / 20);
         sdaMeasure(1'b0, (350 + 50 * c + 19) / 20);
      end
      // Fast and slow watchdog with SDA high free the bus, disabled does not; an edge clears it
      wr(8'h0F, 8'h02, 1'b0);
      kick();
      cyc(2400);
      chk(busFree, 1'b0);
      cyc(200);
      chk(busFree, 1'b1);
      kick();
      cyc(4);
      chk(busFree, 1'b0);
      wr(8'h0F, 8'h03, 1'b0);
      kick();
      cyc(3500);
      chk({busFree, busRecovering}, 2'b00);
      wr(8'h0F, 8'h00, 1'b0);
      kick();
      cyc(2800);
      chk(busFree, 1'b0);
      cyc(300);
      chk(busFree, 1'b1);
      // Stuck SDA: expiry drives nine SCL clocks, then stops
      wr(8'h0F, 8'h02, 1'b0);
      @(posedge clk_sys);
      holdSdaLow <= 1'b1;
      kick();
      cyc(2400);
      chk(busRecovering, 1'b0);
      n = 0;
      m = 0;
      prev = sclOe;
      repeat (5500) begin
         @(negedge clk_sys);
         if (sclOe && !prev) n++;
         if (busRecovering) m++;
         prev = sclOe;
      end
      chk(n, 9);
      // Nine clocks of 250 cycles low and 250 cycles high
      chk(m, 4500);
      chk({sclDrv, sdaDrv}, 2'b00);
      chk(busRecovering, 1'b0);
      @(posedge clk_sys);
      holdSdaLow <= 1'b0;
      cyc(4);
      reportAndStop();
   end

   // Hang guard, well beyond the expected run length
   initial begin
      repeat (40000) @(posedge clk_sys);
      errTotal++;
      reportAndStop();
   end
endmodule
